// file: src/asm_defs.svh
// Purpose: constants of the security command block
// Assumes: 16-bit sector words, 256 words per sector
// Notes: opcodes are the task-file command codes
`ifndef ASM_DEFS_SVH
`define ASM_DEFS_SVH

`define ASM_OP_SET_PW       8'hf1
`define ASM_OP_UNLOCK       8'hf2
`define ASM_OP_ERASE_PREP   8'hf3
`define ASM_OP_ERASE_UNIT   8'hf4
`define ASM_OP_FREEZE       8'hf5
`define ASM_OP_DISABLE_PW   8'hf6

`define ASM_ATTEMPT_INIT    3'h5
`define ASM_SECCNT_FREEZE   8'h00
`define ASM_LAST_WORD       8'hff
`define ASM_PW_FIRST        8'h01
`define ASM_PW_LAST         8'h10
`define ASM_CTRL_IDENT_BIT  0
`define ASM_CTRL_LEVEL_BIT  8

`endif

// file: src/asm_pkg.sv
// Purpose: types of the security command block
// Assumes: nothing beyond the constants header
// Notes: command kinds are decoded from the opcode once
package asm_pkg;

   typedef enum logic [1:0] {
      ASM_ST_BOOT,
      ASM_ST_IDLE,
      ASM_ST_RECV
   } asm_state_t;

   typedef enum logic [1:0] {
      ASM_K_SET,
      ASM_K_UNLOCK,
      ASM_K_ERASE
   } asm_kind_t;

endpackage : asm_pkg

// file: src/asm_core.sv
// Purpose: security lock, freeze, erase pairing and unlock counter
// Assumes: one command at a time; sector words arrive in order 0..255
// Notes: passwords and lock setting survive reset like nonvolatile storage
`timescale 1ns/1ps
`default_nettype none
`include "asm_defs.svh"

// Contract
// - erase unit password mismatch aborts
// - erase unit without prior prepare aborts
// - freeze lock sets frozen flag
// - frozen rejects set, unlock, disable, erase
// - only reset clears frozen flag
// - freeze while frozen completes, stays frozen
// - freeze completion writes zero sector count
// - no security support: freeze acts as wear-level
// - set password receives one data sector
// - word0 bit0 ident, bit8 level, words1-16 password
// - user high: lock next reset, both unlock
// - user maximum: lock next reset, user only
// - master set keeps lock and level
// - master unlock at high compares master password
// - master unlock at maximum is rejected
// - user unlock compares user password
// - failed unlock while locked aborts, decrements counter
// - attempt counter loads five at reset
// - counter zero aborts unlock and erase unit
// - unlock while unlocked keeps counter
// - compare sector word0 bit0 selects password
module asm_core (
   input wire logic i_core_clk,              // 25 MHz core clock
   input wire logic i_reset_n,               // power-on or hardware reset
   input wire logic i_security_supported,    // security feature set present
   input wire logic i_nv_clear,              // clear stored lock setting and level; passwords kept
   input wire logic i_cmd_valid,             // command register written
   input wire logic [7:0] i_cmd_code,        // command opcode
   input wire logic i_data_valid,            // sector word strobe
   input wire logic [15:0] i_data_word,      // sector word
   output logic o_busy,                      // not ready for a command
   output logic o_data_req,                  // expecting sector words
   output logic o_done,                      // command complete pulse
   output logic o_abort,                     // aborted, beside o_done
   output logic o_seccnt_we,                 // sector count write pulse
   output logic [7:0] o_seccnt,              // sector count value
   output logic o_erase,                     // erase all user data pulse
   output logic o_wear_level,                // run wear-level command pulse
   output logic o_locked,                    // lock mode active
   output logic o_frozen,                    // frozen mode
   output logic o_level_max,                 // maximum security level
   output logic [2:0] o_attempts             // unlock attempts left
);
   import asm_pkg::*;

   typedef struct packed {
      asm_state_t state;
      asm_kind_t kind;
      logic frozen;
      logic prepared;
      logic locked;
      logic [2:0] attempts;
      logic ident;
      logic level;
      logic [7:0] widx;
      logic mismatch;
      logic done;
      logic abort;
      logic seccnt_we;
      logic erase;
      logic wear;
   } asm_regs_t;

   asm_regs_t r;
   asm_regs_t next_r;

   // password store: user at 0..15, master at 16..31; no reset, kept like flash
   logic [15:0] pw_mem [0:31];
   logic user_set;
   logic level_max;

   logic word_take;
   logic pw_word;
   logic [15:0] stored_word;

   function automatic logic [4:0] asm_pw_addr(input logic ident, input logic [7:0] widx);
      logic [7:0] off;
      off = widx - `ASM_PW_FIRST;
      asm_pw_addr = {ident, off[3:0]};
   endfunction : asm_pw_addr

   assign word_take = (r.state == ASM_ST_RECV) && i_data_valid;
   assign pw_word = (r.widx >= `ASM_PW_FIRST) && (r.widx <= `ASM_PW_LAST);
   assign stored_word = pw_mem[asm_pw_addr(r.ident, r.widx)];

   always_comb begin
      next_r = r;
      next_r.done = 1'b0;
      next_r.abort = 1'b0;
      next_r.seccnt_we = 1'b0;
      next_r.erase = 1'b0;
      next_r.wear = 1'b0;
      case (r.state)
         ASM_ST_BOOT: begin
            // lock mode set by an earlier user password takes effect here
            next_r.locked = user_set;
            next_r.state = ASM_ST_IDLE;
         end
         ASM_ST_IDLE: begin
            if (i_cmd_valid) begin
               next_r.prepared = 1'b0;
               next_r.widx = 8'h00;
               next_r.mismatch = 1'b0;
               case (i_cmd_code)
                  `ASM_OP_ERASE_PREP: begin
                     next_r.prepared = i_security_supported;
                     next_r.done = 1'b1;
                     next_r.abort = !i_security_supported;
                  end
                  `ASM_OP_FREEZE: begin
                     next_r.done = 1'b1;
                     if (!i_security_supported) begin
                        next_r.wear = 1'b1;
                     end else begin
                        next_r.frozen = 1'b1;
                        next_r.seccnt_we = 1'b1;
                     end
                  end
                  `ASM_OP_SET_PW: begin
                     if (r.frozen || !i_security_supported) begin
                        next_r.done = 1'b1;
                        next_r.abort = 1'b1;
                     end else begin
                        next_r.kind = ASM_K_SET;
                        next_r.state = ASM_ST_RECV;
                     end
                  end
                  `ASM_OP_UNLOCK: begin
                     if (r.frozen || !i_security_supported || r.attempts == 3'h0) begin
                        next_r.done = 1'b1;
                        next_r.abort = 1'b1;
                     end else begin
                        next_r.kind = ASM_K_UNLOCK;
                        next_r.state = ASM_ST_RECV;
                     end
                  end
                  `ASM_OP_ERASE_UNIT: begin
                     if (r.frozen || !i_security_supported || r.attempts == 3'h0 || !r.prepared) begin
                        next_r.done = 1'b1;
                        next_r.abort = 1'b1;
                     end else begin
                        next_r.kind = ASM_K_ERASE;
                        next_r.state = ASM_ST_RECV;
                     end
                  end
                  `ASM_OP_DISABLE_PW: begin
                     // only the frozen refusal is handled here
                     if (r.frozen) begin
                        next_r.done = 1'b1;
                        next_r.abort = 1'b1;
                     end
                  end
                  default: begin
                  end
               endcase
            end
         end
         ASM_ST_RECV: begin
            if (word_take) begin
               next_r.widx = r.widx + 8'h01;
               if (r.widx == 8'h00) begin
                  next_r.ident = i_data_word[`ASM_CTRL_IDENT_BIT];
                  next_r.level = i_data_word[`ASM_CTRL_LEVEL_BIT];
               end
               if (pw_word && stored_word != i_data_word) begin
                  next_r.mismatch = 1'b1;
               end
               if (r.widx == `ASM_LAST_WORD) begin
                  next_r.state = ASM_ST_IDLE;
                  next_r.done = 1'b1;
                  case (r.kind)
                     ASM_K_SET: begin
                        next_r.abort = 1'b0;
                     end
                     ASM_K_UNLOCK: begin
                        if (r.ident && level_max) begin
                           next_r.abort = 1'b1;
                        end else if (next_r.mismatch) begin
                           next_r.abort = 1'b1;
                           if (r.locked) begin
                              next_r.attempts = r.attempts - 3'h1;
                           end
                        end else begin
                           next_r.locked = 1'b0;
                        end
                     end
                     ASM_K_ERASE: begin
                        if (next_r.mismatch) begin
                           next_r.abort = 1'b1;
                        end else begin
                           next_r.erase = 1'b1;
                           next_r.locked = 1'b0;
                        end
                     end
                     default: begin
                        next_r.abort = 1'b1;
                     end
                  endcase
               end
            end
         end
         default: begin
            next_r.state = ASM_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         r <= '0;
         r.state <= ASM_ST_BOOT;
         r.kind <= ASM_K_SET;
         r.frozen <= 1'b0;
         r.attempts <= `ASM_ATTEMPT_INIT;
      end else begin
         r <= next_r;
      end
   end

   // stored setup is written as the sector streams in; set never aborts once data flows
   always_ff @(posedge i_core_clk) begin
      if (i_nv_clear) begin
         user_set <= 1'b0;
         level_max <= 1'b0;
      end else if (word_take && r.kind == ASM_K_SET && r.widx == `ASM_LAST_WORD && !r.ident) begin
         user_set <= 1'b1;
         level_max <= r.level;
      end
      if (word_take && r.kind == ASM_K_SET && pw_word) begin
         pw_mem[asm_pw_addr(r.ident, r.widx)] <= i_data_word;
      end
   end

   assign o_busy = (r.state != ASM_ST_IDLE);
   assign o_data_req = (r.state == ASM_ST_RECV);
   assign o_done = r.done;
   assign o_abort = r.abort;
   assign o_seccnt_we = r.seccnt_we;
   assign o_seccnt = `ASM_SECCNT_FREEZE;
   assign o_erase = r.erase;
   assign o_wear_level = r.wear;
   assign o_locked = r.locked;
   assign o_frozen = r.frozen;
   assign o_level_max = level_max;
   assign o_attempts = r.attempts;

   a_freeze_sets: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      (r.state == ASM_ST_IDLE && i_cmd_valid && i_cmd_code == `ASM_OP_FREEZE && i_security_supported)
      |=> (o_frozen && o_done && !o_abort && o_seccnt_we))
      else $error("freeze lock did not set frozen");

   a_frozen_sticks: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      o_frozen |=> o_frozen)
      else $error("frozen flag cleared without reset");

   a_frozen_rejects: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      (r.state == ASM_ST_IDLE && i_cmd_valid && o_frozen &&
       (i_cmd_code == `ASM_OP_UNLOCK || i_cmd_code == `ASM_OP_ERASE_UNIT || i_cmd_code == `ASM_OP_SET_PW))
      |=> (o_done && o_abort && !o_data_req))
      else $error("frozen device accepted a lock command");

   a_wear_swap: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      (r.state == ASM_ST_IDLE && i_cmd_valid && i_cmd_code == `ASM_OP_FREEZE && !i_security_supported)
      |=> (o_wear_level && !o_seccnt_we && $stable(o_frozen)))
      else $error("freeze without security not sent to wear level");

   a_erase_needs_prep: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      (r.state == ASM_ST_IDLE && i_cmd_valid && i_cmd_code == `ASM_OP_ERASE_UNIT && !r.prepared)
      |=> (o_done && o_abort))
      else $error("erase unit without prepare not aborted");

   a_prep_cancel: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      (r.state == ASM_ST_IDLE && i_cmd_valid && i_cmd_code != `ASM_OP_ERASE_PREP) |=> !r.prepared)
      else $error("prepared state survived another command");

   a_count_zero: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      (r.state == ASM_ST_IDLE && i_cmd_valid && o_attempts == 3'h0 && i_cmd_code == `ASM_OP_UNLOCK)
      |=> (o_abort && o_attempts == 3'h0))
      else $error("unlock taken with no attempts left");

   a_count_step: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      (o_attempts != $past(o_attempts)) |-> (o_attempts == $past(o_attempts) - 3'h1 && o_abort && $past(o_locked)))
      else $error("attempt counter moved without a locked failure");

   a_erase_clean: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      o_erase |-> (o_done && !o_abort && !o_locked))
      else $error("erase pulse without clean unlocked completion");

   a_boot_count: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      (r.state == ASM_ST_BOOT) |-> (o_attempts == 3'h5 && !o_frozen))
      else $error("counter not five after reset");

   a_abort_beside: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      o_abort |-> o_done)
      else $error("abort flag without completion");

   a_sector_start: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      (r.state == ASM_ST_IDLE && i_cmd_valid && i_cmd_code == `ASM_OP_SET_PW &&
       !o_frozen && i_security_supported)
      |=> (o_data_req && o_busy && !o_done))
      else $error("set password did not ask for its sector");

   a_set_completes: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      (word_take && r.kind == ASM_K_SET && r.widx == `ASM_LAST_WORD) |=> (o_done && !o_abort && !o_data_req))
      else $error("set password sector not completed cleanly");

   a_level_taken: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      (word_take && r.kind == ASM_K_SET && r.widx == `ASM_LAST_WORD && !r.ident && !i_nv_clear)
      |=> (o_level_max == r.level))
      else $error("user password did not set the level");

   a_master_keeps: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      (word_take && r.kind == ASM_K_SET && r.ident && r.widx != 8'h00 && !i_nv_clear)
      |=> ($stable(o_level_max) && $stable(o_locked)))
      else $error("master password changed level or lock");

   a_max_refuses: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      (word_take && r.kind == ASM_K_UNLOCK && r.widx == `ASM_LAST_WORD && r.ident && level_max)
      |=> (o_done && o_abort && $stable(o_attempts) && $stable(o_locked)))
      else $error("master unlock accepted at maximum level");

   a_unlock_match: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      (word_take && r.kind == ASM_K_UNLOCK && r.widx == `ASM_LAST_WORD && !r.mismatch &&
       !(r.ident && level_max))
      |=> (o_done && !o_abort && !o_locked))
      else $error("matching unlock did not clear lock");

   a_unlock_miss: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      (word_take && r.kind == ASM_K_UNLOCK && r.widx == `ASM_LAST_WORD && r.mismatch && !r.ident && o_locked)
      |=> (o_done && o_abort && o_locked && o_attempts == $past(o_attempts) - 3'h1))
      else $error("failed unlock did not count down");

   a_unlocked_keeps: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      !o_locked |=> $stable(o_attempts))
      else $error("attempt counter moved while unlocked");

   a_count_floor: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      (o_attempts == 3'h0) |=> (o_attempts == 3'h0))
      else $error("empty attempt counter refilled without reset");

   a_erase_gate: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      (r.state == ASM_ST_IDLE && i_cmd_valid && i_cmd_code == `ASM_OP_ERASE_UNIT && o_attempts == 3'h0)
      |=> (o_done && o_abort && !o_data_req))
      else $error("erase unit taken with no attempts left");

   a_erase_miss: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      (word_take && r.kind == ASM_K_ERASE && r.widx == `ASM_LAST_WORD && r.mismatch)
      |=> (o_done && o_abort && !o_erase && $stable(o_attempts)))
      else $error("erase with wrong password not aborted");

   a_seccnt_zero: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      o_seccnt_we |-> (o_done && o_seccnt == `ASM_SECCNT_FREEZE && o_frozen))
      else $error("sector count write without freeze completion");

   a_wear_only: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      o_wear_level |-> (o_done && !o_abort && !$past(i_security_supported)))
      else $error("wear level pulse with security present");

   a_frozen_again: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      (r.state == ASM_ST_IDLE && i_cmd_valid && i_cmd_code == `ASM_OP_FREEZE && o_frozen)
      |=> (o_frozen && o_done && !o_abort))
      else $error("freeze while frozen did not complete");

   a_disable_frozen: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      (r.state == ASM_ST_IDLE && i_cmd_valid && o_frozen && i_cmd_code == `ASM_OP_DISABLE_PW)
      |=> (o_done && o_abort))
      else $error("frozen device accepted disable password");

endmodule : asm_core
`default_nettype wire

// file: verif/asm_host.sv
// Purpose: host side that issues task-file commands and sends sector words
// Assumes: one command at a time; drives right after rising edges
// Notes: released data lines show the inverse of the last word
`timescale 1ns/1ps
`default_nettype none
module asm_host (
   input wire logic i_core_clk, // core clock
   input wire logic i_busy, // device not ready
   input wire logic i_data_req, // device wants words
   input wire logic i_done, // completion pulse
   input wire logic i_abort, // aborted flag
   input wire logic i_seccnt_we, // sector count write
   input wire logic i_erase, // erase pulse
   input wire logic i_wear_level, // wear-level pulse
   output logic o_cmd_valid, // command strobe
   output logic [7:0] o_cmd_code, // opcode
   output logic o_data_valid, // word strobe
   output logic [15:0] o_data_word // sector word
);
   initial begin
      o_cmd_valid = 1'b0;
      o_cmd_code = 8'h00;
      o_data_valid = 1'b0;
      o_data_word = 16'h0000;
   end
   // res = {done, abort, seccnt_we, erase, wear}; zero when nothing answered
   task automatic run(input logic [7:0] code, input logic [15:0] ctrl, input logic [15:0] pw,
                      output logic [4:0] res);
      int n;
      res = 5'h00;
      n = 0;
      while (i_busy !== 1'b0) begin
         @(posedge i_core_clk);
         #1;
      end
      @(posedge i_core_clk);
      o_cmd_valid <= 1'b1;
      o_cmd_code <= code;
      @(posedge i_core_clk);
      o_cmd_valid <= 1'b0;
      o_cmd_code <= ~code;
      #1;
      while (n < 4 && res[4] !== 1'b1) begin
         if (i_data_req === 1'b1) begin
            for (int i = 0; i < 256; i++) begin
               @(posedge i_core_clk);
               o_data_valid <= 1'b1;
               o_data_word <= (i == 0) ? ctrl : (i <= 16) ? pw + 16'(i) : ~pw;
            end
            @(posedge i_core_clk);
            o_data_valid <= 1'b0;
            o_data_word <= ~o_data_word;
            #1;
         end
         if (i_done === 1'b1) res = {1'b1, i_abort, i_seccnt_we, i_erase, i_wear_level};
         else begin
            @(posedge i_core_clk);
            #1;
            n++;
         end
      end
   endtask : run
endmodule : asm_host
`default_nettype wire

// file: verif/tb_asm_core.sv
// Purpose: self-checking bench of the security command block
// Assumes: model state mirrors the lock, freeze, level and counter
// Notes: passwords come from the lfsr; words 1-16 derive from them
`timescale 1ns/1ps
`default_nettype none
`include "asm_defs.svh"
module tb_asm_core;
   logic i_core_clk = 1'b0, i_reset_n = 1'b0, sup = 1'b1, nv = 1'b0;
   logic cv, dv, busy, dreq, done, ab, we, er, wl, lk, fz, lmax;
   logic [7:0] code, seccnt;
   logic [15:0] word, pu, pm;
   logic [2:0] att;
   int err_total = 0, samples_checked = 0, cycles = 0;
   int m_locked = 0, m_frozen = 0, m_att = 5, m_lmax = 0, m_uset = 0, m_prep = 0;
   logic [15:0] m_upw = 16'h0000, m_mpw = 16'h0000;
   logic [31:0] lfsr_q = 32'h78eb9836;

   asm_core asm_core_inst (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_security_supported(sup),
      .i_nv_clear(nv), .i_cmd_valid(cv), .i_cmd_code(code), .i_data_valid(dv), .i_data_word(word),
      .o_busy(busy), .o_data_req(dreq), .o_done(done), .o_abort(ab), .o_seccnt_we(we), .o_seccnt(seccnt),
      .o_erase(er), .o_wear_level(wl), .o_locked(lk), .o_frozen(fz), .o_level_max(lmax), .o_attempts(att));
   asm_host asm_host_inst (.i_core_clk(i_core_clk), .i_busy(busy), .i_data_req(dreq), .i_done(done),
      .i_abort(ab), .i_seccnt_we(we), .i_erase(er), .i_wear_level(wl), .o_cmd_valid(cv),
      .o_cmd_code(code), .o_data_valid(dv), .o_data_word(word));

   always #20 i_core_clk = ~i_core_clk;
   always @(posedge i_core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         close_out();
      end
   end

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : close_out

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic new_pw(output logic [15:0] pw);
      lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
      pw = lfsr_q[15:0];
   endtask : new_pw

   function automatic logic [4:0] predict(input logic [7:0] op, input logic [15:0] ctrl, input logic [15:0] pw);
      logic [4:0] r;
      logic ok;
      r = 5'h10;
      ok = ctrl[0] ? (pw == m_mpw) : (pw == m_upw);
      if (sup == 1'b0) r = (op == `ASM_OP_FREEZE) ? 5'h11 : 5'h18;
      else if (op == `ASM_OP_FREEZE) begin
         r = 5'h14;
         m_frozen = 1;
      end else if (m_frozen != 0 && op != `ASM_OP_ERASE_PREP) r = 5'h18;
      else if (op == `ASM_OP_SET_PW) begin
         if (ctrl[0]) m_mpw = pw;
         else begin
            m_upw = pw;
            m_uset = 1;
            m_lmax = ctrl[8];
         end
      end else if (op == `ASM_OP_UNLOCK) begin
         if (m_att == 0 || (ctrl[0] && m_lmax != 0)) r = 5'h18;
         else if (ok) m_locked = 0;
         else begin
            r = 5'h18;
            if (m_locked != 0) m_att--;
         end
      end else if (op == `ASM_OP_ERASE_UNIT) begin
         if (m_att == 0 || m_prep == 0 || !ok) r = 5'h18;
         else begin
            r = 5'h12;
            m_locked = 0;
         end
      end
      m_prep = (op == `ASM_OP_ERASE_PREP && sup);
      return r;
   endfunction : predict

   task automatic state_chk();
      check(16'({lk, fz, lmax, att}), 16'({m_locked[0], m_frozen[0], m_lmax[0], m_att[2:0]}));
   endtask : state_chk

   task automatic do_cmd(input logic [7:0] op, input logic [15:0] ctrl, input logic [15:0] pw);
      logic [4:0] res, exp;
      exp = predict(op, ctrl, pw);
      asm_host_inst.run(op, ctrl, pw, res);
      check(16'(res), 16'(exp));
      state_chk();
   endtask : do_cmd

   task automatic hw_reset();
      @(posedge i_core_clk);
      i_reset_n <= 1'b0;
      repeat (4) @(posedge i_core_clk);
      i_reset_n <= 1'b1;
      repeat (2) @(posedge i_core_clk);
      #1;
      m_frozen = 0;
      m_att = 5;
      m_prep = 0;
      m_locked = m_uset;
      state_chk();
   endtask : hw_reset

   initial begin
      repeat (4) @(posedge i_core_clk);
      i_reset_n <= 1'b1;
      repeat (2) @(posedge i_core_clk);
      nv <= 1'b1;
      @(posedge i_core_clk);
      nv <= 1'b0;
      hw_reset();
      new_pw(pm);
      new_pw(pu);
      do_cmd(`ASM_OP_SET_PW, 16'h0001, pm);
      do_cmd(`ASM_OP_SET_PW, 16'h0000, pu);
      do_cmd(`ASM_OP_UNLOCK, 16'h0000, ~pu);
      hw_reset();
      do_cmd(`ASM_OP_UNLOCK, 16'h0001, pm);
      hw_reset();
      repeat (5) do_cmd(`ASM_OP_UNLOCK, 16'h0000, ~pu);
      do_cmd(`ASM_OP_UNLOCK, 16'h0000, pu);
      do_cmd(`ASM_OP_ERASE_PREP, 16'h0000, 16'h0000);
      do_cmd(`ASM_OP_ERASE_UNIT, 16'h0000, pu);
      hw_reset();
      do_cmd(`ASM_OP_ERASE_UNIT, 16'h0000, pu);
      do_cmd(`ASM_OP_ERASE_PREP, 16'h0000, 16'h0000);
      do_cmd(`ASM_OP_UNLOCK, 16'h0000, ~pu);
      do_cmd(`ASM_OP_ERASE_UNIT, 16'h0000, pu);
      do_cmd(`ASM_OP_ERASE_PREP, 16'h0000, 16'h0000);
      do_cmd(`ASM_OP_ERASE_UNIT, 16'h0000, ~pu);
      do_cmd(`ASM_OP_ERASE_PREP, 16'h0000, 16'h0000);
      do_cmd(`ASM_OP_ERASE_UNIT, 16'h0001, pm);
      new_pw(pu);
      new_pw(pm);
      do_cmd(`ASM_OP_SET_PW, 16'h0100, pu);
      do_cmd(`ASM_OP_SET_PW, 16'h0101, pm);
      hw_reset();
      do_cmd(`ASM_OP_UNLOCK, 16'h0001, pm);
      do_cmd(`ASM_OP_UNLOCK, 16'h0000, pu);
      do_cmd(`ASM_OP_FREEZE, 16'h0000, 16'h0000);
      check(16'(seccnt), 16'h0000);
      do_cmd(`ASM_OP_FREEZE, 16'h0000, 16'h0000);
      do_cmd(`ASM_OP_SET_PW, 16'h0000, pu);
      do_cmd(`ASM_OP_UNLOCK, 16'h0000, pu);
      do_cmd(`ASM_OP_DISABLE_PW, 16'h0000, pu);
      do_cmd(`ASM_OP_ERASE_UNIT, 16'h0000, pu);
      hw_reset();
      @(posedge i_core_clk);
      sup <= 1'b0;
      @(posedge i_core_clk);
      do_cmd(`ASM_OP_FREEZE, 16'h0000, 16'h0000);
      do_cmd(`ASM_OP_ERASE_PREP, 16'h0000, 16'h0000);
      close_out();
   end
endmodule : tb_asm_core
`default_nettype wire
